/* common/atc_pkg.sv */
// constants shared by the asynchronous timer clocking block
package atc_pkg;
  // register byte addresses
  localparam logic [7:0] ATC_ADDR_CTRL_A  = 8'hb0;
  localparam logic [7:0] ATC_ADDR_CTRL_B  = 8'hb1;
  localparam logic [7:0] ATC_ADDR_COUNTER = 8'hb2;
  localparam logic [7:0] ATC_ADDR_CMP_A   = 8'hb3;
  localparam logic [7:0] ATC_ADDR_CMP_B   = 8'hb4;
  localparam logic [7:0] ATC_ADDR_STATUS  = 8'hb6;
  localparam logic [7:0] ATC_ADDR_GTC     = 8'hb7;
  // reset value of every register
  localparam logic [7:0] ATC_RST_BYTE     = 8'h00;
  // async status register field positions
  localparam int ATC_STAT_ASYNC   = 5;
  localparam int ATC_STAT_CNT_UB  = 4;
  localparam int ATC_STAT_CMPA_UB = 3;
  localparam int ATC_STAT_CMPB_UB = 2;
  localparam int ATC_STAT_CTLA_UB = 1;
  localparam int ATC_STAT_CTLB_UB = 0;
  // general timer control: prescaler reset strobe bit
  localparam int ATC_GTC_PSR      = 1;
  // control register fields
  localparam int ATC_CTLB_TOP_BIT = 3;
  localparam int ATC_COMA_HI      = 7;
  localparam int ATC_COMA_LO      = 6;
  localparam logic [7:0] ATC_CTLA_MASK = 8'hf3;
  localparam logic [7:0] ATC_CTLB_MASK = 8'h0f;
  // commit after this many timer source edges (oscillator rising edges when async, clk cycles otherwise)
  localparam logic [1:0] ATC_COMMIT_EDGES = 2'h2;
  // processor cycles of interrupt flag synchronisation
  localparam int ATC_FLAG_SYNC = 3;
  // waveform mode codes
  localparam logic [2:0] ATC_WGM_NORMAL  = 3'h0;
  localparam logic [2:0] ATC_WGM_PC_FF   = 3'h1;
  localparam logic [2:0] ATC_WGM_CTC     = 3'h2;
  localparam logic [2:0] ATC_WGM_FAST_FF = 3'h3;
  localparam logic [2:0] ATC_WGM_PC_CMP  = 3'h5;
  localparam logic [2:0] ATC_WGM_FAST_CMP = 3'h7;
  // clock select codes
  localparam logic [2:0] ATC_CS_STOP = 3'h0;
  localparam logic [2:0] ATC_CS_DIV1 = 3'h1;
  localparam logic [2:0] ATC_CS_DIV8 = 3'h2;
  localparam logic [2:0] ATC_CS_DIV32 = 3'h3;
  localparam logic [2:0] ATC_CS_DIV64 = 3'h4;
  localparam logic [2:0] ATC_CS_DIV128 = 3'h5;
  localparam logic [2:0] ATC_CS_DIV256 = 3'h6;
  localparam logic [2:0] ATC_CS_DIV1024 = 3'h7;
  // prescaler terminal masks
  localparam logic [9:0] ATC_M8    = 10'h007;
  localparam logic [9:0] ATC_M32   = 10'h01f;
  localparam logic [9:0] ATC_M64   = 10'h03f;
  localparam logic [9:0] ATC_M128  = 10'h07f;
  localparam logic [9:0] ATC_M256  = 10'h0ff;
  localparam logic [9:0] ATC_M1024 = 10'h3ff;
  // counter limits
  localparam logic [7:0] ATC_MAX    = 8'hff;
  localparam logic [7:0] ATC_BOTTOM = 8'h00;
  // sleep mode codes that stop the oscillator
  localparam logic [2:0] ATC_SLEEP_PDOWN   = 3'h2;
  localparam logic [2:0] ATC_SLEEP_STANDBY = 3'h6;
endpackage : atc_pkg

/* logic/atc_hold_reg.sv */
// holding register with busy flag, committed after edge_tick pulses
`timescale 1ns/1ps
module atc_hold_reg (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic       edge_tick,
  output logic            busy,
  output logic            commit,
  output logic [7:0]      value
);
  logic [1:0] edges_reg;

  // a new write restarts the count and wins over a commit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy      <= 1'b0;
      commit    <= 1'b0;
      value     <= atc_pkg::ATC_RST_BYTE;
      edges_reg <= 2'h0;
    end else begin
      commit <= 1'b0;
      if (wr) begin
        busy      <= 1'b1;
        value     <= wdata;
        edges_reg <= 2'h0;
      end else if (busy && edge_tick) begin
        if (edges_reg == atc_pkg::ATC_COMMIT_EDGES - 2'h1) begin
          busy   <= 1'b0;
          commit <= 1'b1;
        end else begin
          edges_reg <= edges_reg + 2'h1;
        end
      end
    end
  end
endmodule : atc_hold_reg

/* logic/atc_sync2.sv */
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module atc_sync2 (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      dout     <= 1'b0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : atc_sync2

/* logic/atc_timer.sv */
// asynchronous timer clocking, prescaler and compare-A output
`timescale 1ns/1ps
module atc_timer (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_we,
  input  wire logic       bus_re,
  output logic [7:0]      bus_rdata,
  input  wire logic       timer_osc_in,
  input  wire logic       compare_a_ddr,
  input  wire logic       sleeping,
  input  wire logic [2:0] sleep_mode,
  output logic            compare_a_output,
  output logic            compare_a_oe,
  output logic            port_detach,
  output logic            osc_run,
  output logic            compare_a_event,
  output logic            overflow_event,
  output logic            wake_request
);
  logic       osc_sync;
  logic       osc_dly_reg;
  logic       osc_rise;
  logic       async_sel_reg;
  logic       src_tick;
  logic       psr_wr;
  logic [9:0] pre_reg;
  logic       tick;
  logic [4:0] wr_vec;
  logic [4:0] busy_vec;
  logic [4:0] commit_vec;
  logic [7:0] hold_val [5];
  logic [7:0] ctl_a_reg;
  logic [7:0] ctl_b_reg;
  logic [7:0] cmp_a_reg;
  logic [7:0] cmp_b_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_copy_reg;
  logic       dir_up_reg;
  logic [2:0] wgm;
  logic [1:0] com_a;
  logic       is_pc;
  logic       is_fast;
  logic       is_nonpwm;
  logic [7:0] top_val;
  logic       suppress;
  logic       match_raw;
  logic       ovf_raw;
  logic       special;
  logic       oc_next;
  logic [2:0] cmp_pipe_reg;
  logic [2:0] ovf_pipe_reg;
  logic       wake_armed_reg;
  logic       stop_mode;

  // oscillator pin is foreign to clk; edge found after synchroniser
  atc_sync2 u_osc_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (timer_osc_in),
    .dout   (osc_sync)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_dly_reg <= 1'b0;
    end else begin
      osc_dly_reg <= osc_sync;
    end
  end

  assign osc_rise = osc_sync & ~osc_dly_reg;
  // i/o clock by default, oscillator edges when async selected
  assign src_tick = async_sel_reg ? osc_rise : 1'b1;

  // write decode for the five holding registers, one bit each
  assign wr_vec[0] = bus_we && (bus_addr == atc_pkg::ATC_ADDR_COUNTER);
  assign wr_vec[1] = bus_we && (bus_addr == atc_pkg::ATC_ADDR_CMP_A);
  assign wr_vec[2] = bus_we && (bus_addr == atc_pkg::ATC_ADDR_CMP_B);
  assign wr_vec[3] = bus_we && (bus_addr == atc_pkg::ATC_ADDR_CTRL_A);
  assign wr_vec[4] = bus_we && (bus_addr == atc_pkg::ATC_ADDR_CTRL_B);
  assign psr_wr    = bus_we && (bus_addr == atc_pkg::ATC_ADDR_GTC)
                     && bus_wdata[atc_pkg::ATC_GTC_PSR];

  // independent holding registers, so pending writes never collide
  for (genvar i = 0; i < 5; i++) begin : g_hold
    atc_hold_reg u_hold (
      .clk       (clk),
      .arst_n    (arst_n),
      .wr        (wr_vec[i]),
      .wdata     (bus_wdata),
      .edge_tick (src_tick),
      .busy      (busy_vec[i]),
      .commit    (commit_vec[i]),
      .value     (hold_val[i])
    );
  end

  // async select and committed compare/control targets
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      async_sel_reg <= 1'b0;
      cmp_a_reg     <= atc_pkg::ATC_RST_BYTE;
      cmp_b_reg     <= atc_pkg::ATC_RST_BYTE;
      ctl_a_reg     <= atc_pkg::ATC_RST_BYTE;
      ctl_b_reg     <= atc_pkg::ATC_RST_BYTE;
    end else begin
      if (bus_we && bus_addr == atc_pkg::ATC_ADDR_STATUS) begin
        async_sel_reg <= bus_wdata[atc_pkg::ATC_STAT_ASYNC];
      end
      if (commit_vec[1]) cmp_a_reg <= hold_val[1];
      if (commit_vec[2]) cmp_b_reg <= hold_val[2];
      if (commit_vec[3]) begin
        ctl_a_reg <= hold_val[3] & atc_pkg::ATC_CTLA_MASK;
      end
      if (commit_vec[4]) begin
        ctl_b_reg <= hold_val[4] & atc_pkg::ATC_CTLB_MASK;
      end
    end
  end

  // prescaler; the reset strobe gives a predictable phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= 10'h000;
    end else if (psr_wr) begin
      pre_reg <= 10'h000;
    end else if (src_tick) begin
      pre_reg <= pre_reg + 10'h001;
    end
  end

  // tap selection from the clock select field
  always_comb begin
    tick = 1'b0;
    unique case (ctl_b_reg[2:0])
      atc_pkg::ATC_CS_STOP:    tick = 1'b0;
      atc_pkg::ATC_CS_DIV1:    tick = src_tick;
      atc_pkg::ATC_CS_DIV8:    tick = src_tick
                                 && ((pre_reg & atc_pkg::ATC_M8) == atc_pkg::ATC_M8);
      atc_pkg::ATC_CS_DIV32:   tick = src_tick
                                 && ((pre_reg & atc_pkg::ATC_M32) == atc_pkg::ATC_M32);
      atc_pkg::ATC_CS_DIV64:   tick = src_tick
                                 && ((pre_reg & atc_pkg::ATC_M64) == atc_pkg::ATC_M64);
      atc_pkg::ATC_CS_DIV128:  tick = src_tick
                                 && ((pre_reg & atc_pkg::ATC_M128) == atc_pkg::ATC_M128);
      atc_pkg::ATC_CS_DIV256:  tick = src_tick
                                 && ((pre_reg & atc_pkg::ATC_M256) == atc_pkg::ATC_M256);
      atc_pkg::ATC_CS_DIV1024: tick = src_tick
                                 && (pre_reg == atc_pkg::ATC_M1024);
    endcase
  end

  // mode decode; reserved codes 4 and 6 count like normal
  assign wgm       = {ctl_b_reg[atc_pkg::ATC_CTLB_TOP_BIT], ctl_a_reg[1:0]};
  assign com_a     = ctl_a_reg[atc_pkg::ATC_COMA_HI:atc_pkg::ATC_COMA_LO];
  assign is_pc     = (wgm == atc_pkg::ATC_WGM_PC_FF)
                     || (wgm == atc_pkg::ATC_WGM_PC_CMP);
  assign is_fast   = (wgm == atc_pkg::ATC_WGM_FAST_FF)
                     || (wgm == atc_pkg::ATC_WGM_FAST_CMP);
  assign is_nonpwm = !is_pc && !is_fast;
  assign top_val   = (wgm == atc_pkg::ATC_WGM_CTC
                     || ctl_b_reg[atc_pkg::ATC_CTLB_TOP_BIT])
                     ? cmp_a_reg : atc_pkg::ATC_MAX;

  // counter; a committed write takes priority over counting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg    <= atc_pkg::ATC_BOTTOM;
      dir_up_reg <= 1'b1;
    end else if (commit_vec[0]) begin
      cnt_reg <= hold_val[0];
    end else if (tick) begin
      if (is_pc) begin
        if (dir_up_reg && cnt_reg == top_val) begin
          dir_up_reg <= 1'b0;
          cnt_reg    <= cnt_reg - 8'h01;
        end else if (!dir_up_reg && cnt_reg == atc_pkg::ATC_BOTTOM) begin
          dir_up_reg <= 1'b1;
          cnt_reg    <= cnt_reg + 8'h01;
        end else begin
          cnt_reg <= dir_up_reg ? cnt_reg + 8'h01 : cnt_reg - 8'h01;
        end
      end else if ((is_fast || wgm == atc_pkg::ATC_WGM_CTC)
                   && cnt_reg == top_val) begin
        cnt_reg <= atc_pkg::ATC_BOTTOM;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  // matching is blind while a compare or counter write is in flight
  assign suppress  = busy_vec[0] | busy_vec[1] | busy_vec[2];
  assign match_raw = tick && !suppress && (cnt_reg == cmp_a_reg);
  assign ovf_raw   = tick && (is_pc
                     ? (!dir_up_reg && cnt_reg == atc_pkg::ATC_BOTTOM)
                     : (cnt_reg == (is_fast ? top_val : atc_pkg::ATC_MAX)));
  assign special   = com_a[1] && !is_nonpwm
                     && (cmp_a_reg == top_val);

  // next compare-A output level from mode and event
  always_comb begin
    oc_next = compare_a_output;
    if (match_raw && !special) begin
      unique case (com_a)
        2'h0: oc_next = compare_a_output;
        2'h1: begin
          if (is_nonpwm || ctl_b_reg[atc_pkg::ATC_CTLB_TOP_BIT]) begin
            oc_next = ~compare_a_output;
          end
        end
        2'h2: oc_next = is_pc ? !dir_up_reg : 1'b0;
        2'h3: oc_next = is_pc ? dir_up_reg : 1'b1;
      endcase
    end else if (tick && is_fast && com_a[1] && cnt_reg == top_val) begin
      oc_next = !com_a[0];
    end else if (tick && is_pc && special && dir_up_reg
                 && cnt_reg == top_val) begin
      oc_next = !com_a[0];
    end
  end

  // pin level moves with the timer tick, not the processor phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_a_output <= 1'b0;
      compare_a_oe     <= 1'b0;
    end else begin
      compare_a_output <= oc_next;
      compare_a_oe     <= (com_a != 2'h0) && compare_a_ddr;
    end
  end

  // flag synchronisation: fixed processor-cycle pipeline after tick
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_pipe_reg <= 3'h0;
      ovf_pipe_reg <= 3'h0;
    end else begin
      cmp_pipe_reg <= {cmp_pipe_reg[1:0], match_raw};
      ovf_pipe_reg <= {ovf_pipe_reg[1:0], ovf_raw};
    end
  end

  assign compare_a_event = cmp_pipe_reg[atc_pkg::ATC_FLAG_SYNC-1];
  assign overflow_event  = ovf_pipe_reg[atc_pkg::ATC_FLAG_SYNC-1];

  // wake starts one timer cycle after the condition while asleep
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_armed_reg <= 1'b0;
      wake_request   <= 1'b0;
    end else if (!sleeping) begin
      wake_armed_reg <= 1'b0;
      wake_request   <= 1'b0;
    end else begin
      if (match_raw || ovf_raw) wake_armed_reg <= 1'b1;
      if (wake_armed_reg && src_tick) wake_request <= 1'b1;
    end
  end

  // oscillator enable follows the async select outside the stop modes; pin detach always follows it
  assign stop_mode = sleeping && (sleep_mode == atc_pkg::ATC_SLEEP_PDOWN
                     || sleep_mode == atc_pkg::ATC_SLEEP_STANDBY);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_run     <= 1'b0;
      port_detach <= 1'b0;
    end else begin
      osc_run     <= async_sel_reg && !stop_mode;
      port_detach <= async_sel_reg;
    end
  end

  // read copy frozen during sleep so wake reads the old value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_copy_reg <= atc_pkg::ATC_BOTTOM;
    end else if (src_tick && !sleeping) begin
      cnt_copy_reg <= cnt_reg;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= atc_pkg::ATC_RST_BYTE;
    end else if (!bus_re) begin
      bus_rdata <= atc_pkg::ATC_RST_BYTE;
    end else begin
      unique case (bus_addr)
        atc_pkg::ATC_ADDR_CTRL_A:  bus_rdata <= ctl_a_reg;
        atc_pkg::ATC_ADDR_CTRL_B:  bus_rdata <= ctl_b_reg;
        atc_pkg::ATC_ADDR_COUNTER: bus_rdata <= cnt_copy_reg;
        atc_pkg::ATC_ADDR_CMP_A:   bus_rdata <= cmp_a_reg;
        atc_pkg::ATC_ADDR_CMP_B:   bus_rdata <= cmp_b_reg;
        atc_pkg::ATC_ADDR_STATUS:  bus_rdata <= {2'h0, async_sel_reg,
                                                busy_vec[0], busy_vec[1],
                                                busy_vec[2], busy_vec[3],
                                                busy_vec[4]};
        default:                   bus_rdata <= atc_pkg::ATC_RST_BYTE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [1:0] chk_edges_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_edges_reg <= 2'h0;
    end else if (wr_vec[0]) begin
      chk_edges_reg <= 2'h0;
    end else if (busy_vec[0] && src_tick && chk_edges_reg != 2'h3) begin
      chk_edges_reg <= chk_edges_reg + 2'h1;
    end
  end

  property p_commit_two_edges;
    $fell(busy_vec[0]) |-> chk_edges_reg == 2'h2;
  endproperty
  a_commit_two_edges: assert property (p_commit_two_edges)
    else $error("counter committed without two edges");

  property p_own_busy;
    !busy_vec[1] && !wr_vec[1] |=> !busy_vec[1];
  endproperty
  a_own_busy: assert property (p_own_busy)
    else $error("compare busy rose without its write");

  property p_status_busy;
    bus_re && bus_addr == atc_pkg::ATC_ADDR_STATUS
      |=> bus_rdata[4] == $past(busy_vec[0]);
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("status busy bit wrong");

  property p_no_match_busy;
    (busy_vec[0] || busy_vec[1]) |-> !match_raw;
  endproperty
  a_no_match_busy: assert property (p_no_match_busy)
    else $error("match while write pending");

  property p_osc_stop;
    stop_mode |=> !osc_run;
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator runs in stop mode");

  property p_copy_hold;
    !(src_tick && !sleeping) |=> $stable(cnt_copy_reg);
  endproperty
  a_copy_hold: assert property (p_copy_hold)
    else $error("read copy changed without edge");

  property p_flag_delay;
    match_raw |-> ##3 compare_a_event;
  endproperty
  a_flag_delay: assert property (p_flag_delay)
    else $error("compare event not three cycles late");

  property p_detach;
    ##1 port_detach == $past(async_sel_reg);
  endproperty
  a_detach: assert property (p_detach)
    else $error("pin detach not following select");

  property p_psr;
    psr_wr |=> pre_reg == 10'h000;
  endproperty
  a_psr: assert property (p_psr)
    else $error("prescaler not reset");

  property p_oe;
    ##1 compare_a_oe == ($past(com_a != 2'h0) && $past(compare_a_ddr));
  endproperty
  a_oe: assert property (p_oe)
    else $error("output enable wrong");

  property p_clear_match;
    match_raw && is_nonpwm && com_a == 2'h2 |=> !compare_a_output;
  endproperty
  a_clear_match: assert property (p_clear_match)
    else $error("clear on match failed");

  property p_wake;
    sleeping && wake_armed_reg && src_tick ##1 sleeping |-> wake_request;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake not started on timer cycle");

  c_commit: cover property ($fell(busy_vec[0]));
  c_match:  cover property (match_raw ##3 compare_a_event);
  c_wake:   cover property ($rose(wake_request));
  c_pc_dir: cover property (is_pc && $fell(dir_up_reg));
endmodule : atc_timer

/* tb/atc_osc_model.sv */
// crystal model driving the timer oscillator pin
`timescale 1ns/1ps
module atc_osc_model #(
  parameter int HALF_NS = 50
) (
  input  wire logic run,
  output logic      osc
);
  // stands low while stopped
  // 10x slower than clk keeps the 4x margin
  // starts stable, so the bench skips the settling wait
  initial begin
    osc = 1'b0;
    forever begin
      if (run === 1'b1) begin
        #(HALF_NS);
        osc = ~osc;
      end else begin
        osc = 1'b0;
        @(posedge run);
        // off the clk edges, so the sampling flop never races the pin
        #2;
      end
    end
  end
endmodule : atc_osc_model

/* tb/tb.sv */
// self-checking bench for the asynchronous timer block
`timescale 1ns/1ps
module tb;
  logic       clk, arst_n, we, re, ddr, slp, osc, oc, oe, det, run, ev;
  logic [7:0] addr, wdata, rdata, d, v, o1;
  logic [2:0] smode;
  logic       ov, wk;
  int         errors, comparisons;
  int         ov_n = 0, n0;
  logic [2:0] sm [4] = '{3'h2, 3'h6, 3'h3, 3'h0};
  logic [7:0] cm [7] = '{8'h40, 8'h80, 8'hc0, 8'h83, 8'hc3, 8'h81, 8'h42};

  atc_timer dut_u (
    .clk(clk), .arst_n(arst_n), .bus_addr(addr), .bus_wdata(wdata),
    .bus_we(we), .bus_re(re), .bus_rdata(rdata), .timer_osc_in(osc),
    .compare_a_ddr(ddr), .sleeping(slp), .sleep_mode(smode),
    .compare_a_output(oc), .compare_a_oe(oe), .port_detach(det),
    .osc_run(run), .compare_a_event(ev), .overflow_event(ov),
    .wake_request(wk)
  );
  atc_osc_model osc_u (.run(run), .osc(osc));

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // toggle, and phase correct matches alternate up and down
  function automatic logic [7:0] exp_oc(logic [7:0] c, logic prev);
    if (c[7:6] == 2'h1 || {1'b0, c[1:0]} == atc_pkg::ATC_WGM_PC_FF)
      return {7'h0, ~prev};
    return {7'h0, c[6]};
  endfunction : exp_oc

  // clear-on-match never reaches the top count, so no overflow
  function automatic logic [7:0] exp_ovf(logic [7:0] c);
    if ({1'b0, c[1:0]} == atc_pkg::ATC_WGM_CTC) return 8'h00;
    return 8'h01;
  endfunction : exp_ovf

  // overflow pulses seen, counted per compare period
  always @(posedge clk) begin
    if (ov === 1'b1) ov_n <= ov_n + 1;
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // one-cycle strobes, launched just after an edge
  task automatic wr(input logic [7:0] a, dat);
    @(posedge clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= dat;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    re   <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // bounded polling; rewriting while busy is not allowed
  task automatic wait_busy;
    int n;
    n = 0;
    rd(atc_pkg::ATC_ADDR_STATUS);
    while ((d & 8'h1f) !== 8'h00) begin
      n++;
      if (n > 80) begin
        errors++;
        summarize();
      end
      rd(atc_pkg::ATC_ADDR_STATUS);
    end
  endtask : wait_busy

  task automatic wait_ev;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > 1000) begin
        errors++;
        summarize();
      end
    end while (ev !== 1'b1);
  endtask : wait_ev

  initial begin
    {arst_n, we, re, ddr, slp} = '0;
    addr = '0;
    wdata = '0;
    smode = '0;
    errors = 0;
    comparisons = 0;
    void'($urandom(84027));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // every place, unmapped 0xb5 too, reads zero
    for (int a = 8'hb0; a <= 8'hb7; a++) begin
      rd(8'(a));
      chk("reset", d, atc_pkg::ATC_RST_BYTE);
    end
    chk("detach", {7'h0, det}, 8'h00);
    // random readback through the holding registers
    repeat (6) begin
      v = 8'($urandom);
      wr(atc_pkg::ATC_ADDR_CTRL_A, v);
      wr(atc_pkg::ATC_ADDR_CMP_B, ~v);
      wait_busy();
      rd(atc_pkg::ATC_ADDR_CTRL_A);
      chk("ctla", d, v & atc_pkg::ATC_CTLA_MASK);
      rd(atc_pkg::ATC_ADDR_CMP_B);
      chk("cmpb", d, ~v);
    end
    // go asynchronous, then two writes back to back
    wr(atc_pkg::ATC_ADDR_STATUS, 8'h20);
    // detach is registered one edge behind the select
    @(posedge clk);
    #1;
    chk("detach", {7'h0, det}, 8'h01);
    v = 8'($urandom);
    wr(atc_pkg::ATC_ADDR_COUNTER, v);
    wr(atc_pkg::ATC_ADDR_CMP_A, 8'h40);
    rd(atc_pkg::ATC_ADDR_STATUS);
    chk("busy", d, 8'h38);
    wait_busy();
    // read copy only follows the next oscillator edge after commit
    repeat (20) @(posedge clk);
    rd(atc_pkg::ATC_ADDR_COUNTER);
    chk("count", d, v);
    // oscillator stops only in the two deep modes
    // sleep entered only after the busy flags cleared
    foreach (sm[i]) begin
      @(posedge clk);
      slp   <= 1'b1;
      smode <= sm[i];
      repeat (4) @(posedge clk);
      #1;
      chk("osc_run", {7'h0, run}, {7'h0, sm[i] != atc_pkg::ATC_SLEEP_PDOWN
          && sm[i] != atc_pkg::ATC_SLEEP_STANDBY});
    end
    @(posedge clk);
    slp <= 1'b0;
    wr(atc_pkg::ATC_ADDR_STATUS, 8'h00);
    wait_busy();
    // synchronous compare-A actions, counter free running
    @(posedge clk);
    ddr <= 1'b1;
    wr(atc_pkg::ATC_ADDR_CTRL_B, {5'h0, atc_pkg::ATC_CS_DIV1});
    foreach (cm[i]) begin
      wr(atc_pkg::ATC_ADDR_CTRL_A, cm[i]);
      wait_busy();
      chk("oe", {7'h0, oe}, 8'h01);
      // the first event may still belong to the previous mode
      repeat (2) wait_ev();
      o1 = {7'h0, oc};
      n0 = ov_n;
      wait_ev();
      chk("oc", {7'h0, oc}, exp_oc(cm[i], o1[0]));
      if ({1'b0, cm[i][1:0]} != atc_pkg::ATC_WGM_PC_FF) begin
        chk("ovf", 8'(ov_n - n0), exp_ovf(cm[i]));
      end
    end
    // a match while asleep raises the wake request
    @(posedge clk);
    slp   <= 1'b1;
    smode <= 3'h3;
    for (int n = 0; n < 300 && wk !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("wake", {7'h0, wk}, 8'h01);
    // driver needs the direction bit as well; wake drops on waking
    @(posedge clk);
    slp <= 1'b0;
    ddr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("oe", {7'h0, oe}, 8'h00);
    chk("wake", {7'h0, wk}, 8'h00);
    // one count per eight clocks, whatever the prescaler phase
    wr(atc_pkg::ATC_ADDR_CTRL_A, 8'h00);
    wr(atc_pkg::ATC_ADDR_CTRL_B, {5'h0, atc_pkg::ATC_CS_DIV8});
    wr(atc_pkg::ATC_ADDR_GTC, 8'(1 << atc_pkg::ATC_GTC_PSR));
    wait_busy();
    rd(atc_pkg::ATC_ADDR_GTC);
    chk("gtc", d, atc_pkg::ATC_RST_BYTE);
    rd(atc_pkg::ATC_ADDR_COUNTER);
    o1 = d;
    repeat (78) @(posedge clk);
    rd(atc_pkg::ATC_ADDR_COUNTER);
    chk("div8", 8'(d - o1), 8'h0a);
    summarize();
  end
endmodule : tb
